// ### logic/bft_config_top.sv
// Contract
// - The individual-response enable bit selects the register response field when 1, the mode pin response when 0.
// - Every high bus input undervoltage detection sets status bit 7 and pulls the fault status output low.
// - Response codes 00 and 11 only flag the fault and keep switching running.
// - Response code 01 stops switching and restarts it about 500 ms after the condition clears.
// - Response code 10 stops switching until the host toggles the switching enable or chip enable.
// - Low bus overvoltage warning code maps 115,110,120,125,130,135,140,145 percent.
// - Low bus overvoltage protection code maps 150,140,130,160,170,180,190,200 percent.
// - The low bus overvoltage register is one writable, protectable byte resetting to 00h with 7:6 reserved.
// - The undervoltage warning register holds high bus code in 5:3, low bus code in 2:0, resets to 0.
// - Low bus undervoltage warning code maps 85,82.5,80,77.5,75,72.5,87.5,90 percent.
// - High bus undervoltage warning code maps 75,71,67,63,58,54,79,83 percent.
`timescale 1ns/1ps
module bft_config_top #(
  parameter int HICCUP_CYCLES = bft_pkg::HICCUP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command register port from the management bus engine
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr_en,
  input wire logic cmd_rd_en,
  input wire logic [7:0] cmd_wdata,
  input wire logic write_protect,
  output logic [7:0] cmd_rdata,
  // Fault detection and status
  input wire logic hv_in_uv_detect,
  input wire logic status_clr,
  output logic hv_in_uv_status,
  output logic fault_status_output_out,
  output logic fault_status_output_oe,
  // Switching control
  input wire logic [1:0] mode_pin_resp,
  input wire logic pwm_enable,
  input wire logic chip_enable,
  output logic pwm_run,
  // Decoded thresholds, tenths of a percent
  output logic [bft_pkg::PCT_W-1:0] lv_ov_warn_pct,
  output logic [bft_pkg::PCT_W-1:0] lv_ov_prot_pct,
  output logic [bft_pkg::PCT_W-1:0] lv_uv_warn_pct,
  output logic [bft_pkg::PCT_W-1:0] hv_uv_warn_pct
);

  localparam logic [bft_pkg::HICCUP_CNT_W-1:0] HIC_LAST = bft_pkg::HICCUP_CNT_W'(HICCUP_CYCLES - 1);

  logic [7:0] ind_en_reg, ind_en_next;
  logic [7:0] fault_ctrl_reg, fault_ctrl_next;
  logic [7:0] ov_thr_reg, ov_thr_next;
  logic [7:0] uv_thr_reg, uv_thr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic status_reg, status_next;
  bft_pkg::bft_state_t state_reg, state_next;
  logic [bft_pkg::HICCUP_CNT_W-1:0] cnt_reg, cnt_next;
  logic pwm_en_d_reg, chip_en_d_reg;
  logic [1:0] resp;
  logic wr_ok;
  logic en_toggle;

  // Register writes; protected writes are dropped silently
  assign wr_ok = cmd_wr_en && !write_protect;
  always_comb begin
    ind_en_next = ind_en_reg;
    fault_ctrl_next = fault_ctrl_reg;
    ov_thr_next = ov_thr_reg;
    uv_thr_next = uv_thr_reg;
    if (wr_ok) begin
      case (cmd_code)
        bft_pkg::CMD_IND_RESP_EN: ind_en_next = cmd_wdata;
        bft_pkg::CMD_FAULT_CTRL: fault_ctrl_next = cmd_wdata;
        bft_pkg::CMD_LOW_BUS_OV_THR: ov_thr_next = cmd_wdata & bft_pkg::THR_USED_MASK;
        bft_pkg::CMD_BUS_UV_WARN_THR: uv_thr_next = cmd_wdata & bft_pkg::THR_USED_MASK;
        default: ;
      endcase
    end
  end

  // Read answer, one cycle after the strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (cmd_rd_en) begin
      case (cmd_code)
        bft_pkg::CMD_IND_RESP_EN: rdata_next = ind_en_reg;
        bft_pkg::CMD_FAULT_CTRL: rdata_next = fault_ctrl_reg;
        bft_pkg::CMD_LOW_BUS_OV_THR: rdata_next = ov_thr_reg;
        bft_pkg::CMD_BUS_UV_WARN_THR: rdata_next = uv_thr_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_en_reg <= bft_pkg::IND_RESP_EN_RST;
      fault_ctrl_reg <= bft_pkg::FAULT_CTRL_RST;
      ov_thr_reg <= bft_pkg::LOW_BUS_OV_THR_RST;
      uv_thr_reg <= bft_pkg::BUS_UV_WARN_THR_RST;
      rdata_reg <= 8'h00;
    end else begin
      ind_en_reg <= ind_en_next;
      fault_ctrl_reg <= fault_ctrl_next;
      ov_thr_reg <= ov_thr_next;
      uv_thr_reg <= uv_thr_next;
      rdata_reg <= rdata_next;
    end
  end
  assign cmd_rdata = rdata_reg;

  assign resp = ind_en_reg[bft_pkg::IND_RESP_EN_BIT] ? fault_ctrl_reg[bft_pkg::HV_IN_UV_RESP_LSB +: 2]
                                                      : mode_pin_resp;

  // Sticky status; a detection in the clear cycle wins
  always_comb begin
    status_next = status_reg;
    if (status_clr) begin
      status_next = 1'b0;
    end
    if (hv_in_uv_detect) begin
      status_next = 1'b1;
    end
  end

  // Enable toggle detection for latch release
  assign en_toggle = (pwm_enable != pwm_en_d_reg) || (chip_enable != chip_en_d_reg);

  // Switching response state machine
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      bft_pkg::BFT_RUN: begin
        if (hv_in_uv_detect && resp == bft_pkg::RESP_HICCUP) begin
          state_next = bft_pkg::BFT_HIC_WAIT;
        end else if (hv_in_uv_detect && resp == bft_pkg::RESP_LATCH) begin
          state_next = bft_pkg::BFT_LATCHED;
        end
      end
      bft_pkg::BFT_HIC_WAIT: begin
        if (!hv_in_uv_detect) begin
          state_next = bft_pkg::BFT_HIC_DELAY;
          cnt_next = '0;
        end
      end
      bft_pkg::BFT_HIC_DELAY: begin
        if (hv_in_uv_detect) begin
          state_next = bft_pkg::BFT_HIC_WAIT;
        end else if (cnt_reg == HIC_LAST) begin
          state_next = bft_pkg::BFT_RUN;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      bft_pkg::BFT_LATCHED: begin
        if (en_toggle) begin
          state_next = bft_pkg::BFT_RUN;
        end
      end
      default: state_next = bft_pkg::BFT_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 1'b0;
      state_reg <= bft_pkg::BFT_RUN;
      cnt_reg <= '0;
      pwm_en_d_reg <= 1'b0;
      chip_en_d_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pwm_en_d_reg <= pwm_enable;
      chip_en_d_reg <= chip_enable;
    end
  end

  // Open-drain fault pin: only ever drives low
  assign hv_in_uv_status = status_reg;
  assign fault_status_output_out = 1'b0;
  assign fault_status_output_oe = status_reg;
  assign pwm_run = (state_reg == bft_pkg::BFT_RUN) && pwm_enable && chip_enable;

  // Threshold codes to percentages
  bft_thr_decode u_decode (
    .clk(clk),
    .rst_n(rst_n),
    .ov_thr(ov_thr_reg),
    .uv_thr(uv_thr_reg),
    .lv_ov_warn_pct(lv_ov_warn_pct),
    .lv_ov_prot_pct(lv_ov_prot_pct),
    .lv_uv_warn_pct(lv_uv_warn_pct),
    .hv_uv_warn_pct(hv_uv_warn_pct)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_latch_entry;
    state_reg == bft_pkg::BFT_RUN && hv_in_uv_detect && resp == bft_pkg::RESP_LATCH;
  endsequence
  sequence s_wr_ov;
    cmd_wr_en && !write_protect && cmd_code == bft_pkg::CMD_LOW_BUS_OV_THR;
  endsequence

  AST_MODE_PIN_USED: assert property (
    !ind_en_reg[7] && mode_pin_resp == 2'h2 && hv_in_uv_detect && state_reg == bft_pkg::BFT_RUN
    |=> state_reg == bft_pkg::BFT_LATCHED) else $error("mode pin response not applied");
  AST_STATUS_SET: assert property (
    hv_in_uv_detect |=> hv_in_uv_status && fault_status_output_oe) else $error("status not set");
  AST_PIN_LOW: assert property (
    hv_in_uv_status |-> fault_status_output_oe && !fault_status_output_out) else $error("pin not low");
  AST_FLAG_ONLY: assert property (
    state_reg == bft_pkg::BFT_RUN && (resp == 2'h0 || resp == 2'h3) && pwm_enable && chip_enable
    |=> state_reg == bft_pkg::BFT_RUN) else $error("flag mode stopped switching");
  AST_HICCUP_STOP: assert property (
    state_reg == bft_pkg::BFT_RUN && hv_in_uv_detect && resp == 2'h1 |=> !pwm_run [*2])
    else $error("hiccup did not stop switching");
  AST_HICCUP_TIME: assert property (
    state_reg == bft_pkg::BFT_RUN && $past(state_reg) == bft_pkg::BFT_HIC_DELAY
    |-> $past(cnt_reg) == HIC_LAST) else $error("hiccup restart early");
  AST_LATCH_HOLD: assert property (
    s_latch_entry ##1 !en_toggle |=> state_reg == bft_pkg::BFT_LATCHED) else $error("latch released");
  AST_LATCH_RELEASE: assert property (
    state_reg == bft_pkg::BFT_LATCHED && en_toggle |=> state_reg == bft_pkg::BFT_RUN)
    else $error("toggle did not release latch");
  AST_READBACK: assert property (
    s_wr_ov ##1 (cmd_rd_en && cmd_code == 8'hB9 && !cmd_wr_en)
    |=> cmd_rdata == ($past(cmd_wdata, 2) & 8'h3F)) else $error("threshold readback mismatch");
  AST_RESERVED_ZERO: assert property (
    $past(cmd_rd_en) && $past(cmd_code) == 8'hBA |-> cmd_rdata[7:6] == 2'h0)
    else $error("reserved bits nonzero");

endmodule : bft_config_top

// ### logic/bft_pkg.sv
package bft_pkg;

  // Command codes of the registers held here
  localparam logic [7:0] CMD_IND_RESP_EN = 8'hB0;
  localparam logic [7:0] CMD_FAULT_CTRL = 8'hB8;
  localparam logic [7:0] CMD_LOW_BUS_OV_THR = 8'hB9;
  localparam logic [7:0] CMD_BUS_UV_WARN_THR = 8'hBA;

  // Field positions
  localparam int IND_RESP_EN_BIT = 7;
  localparam int HV_IN_UV_RESP_LSB = 6;
  localparam int WARN_LSB = 0;
  localparam int PROT_LSB = 3;
  localparam int HV_UV_WARN_LSB = 3;
  localparam int LV_UV_WARN_LSB = 0;
  localparam logic [7:0] THR_USED_MASK = 8'h3F;

  // Values after reset
  localparam logic [7:0] IND_RESP_EN_RST = 8'h00;
  localparam logic [7:0] FAULT_CTRL_RST = 8'h00;
  localparam logic [7:0] LOW_BUS_OV_THR_RST = 8'h00;
  localparam logic [7:0] BUS_UV_WARN_THR_RST = 8'h00;

  // Response codes
  localparam logic [1:0] RESP_FLAG = 2'h0;
  localparam logic [1:0] RESP_HICCUP = 2'h1;
  localparam logic [1:0] RESP_LATCH = 2'h2;
  localparam logic [1:0] RESP_FLAG_ALT = 2'h3;

  // Hiccup restart delay
  localparam int CLK_MHZ = 125;
  localparam int HICCUP_MS = 500;
  localparam int HICCUP_CYCLES = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int HICCUP_CNT_W = 26;

  // Thresholds in tenths of a percent of target voltage
  localparam int PCT_W = 11;
  localparam logic [PCT_W-1:0] LV_OV_WARN_TBL [8] = '{11'h47E, 11'h44C, 11'h4B0, 11'h4E2,
                                                      11'h514, 11'h546, 11'h578, 11'h5AA};
  localparam logic [PCT_W-1:0] LV_OV_PROT_TBL [8] = '{11'h5DC, 11'h578, 11'h514, 11'h640,
                                                      11'h6A4, 11'h708, 11'h76C, 11'h7D0};
  localparam logic [PCT_W-1:0] LV_UV_WARN_TBL [8] = '{11'h352, 11'h339, 11'h320, 11'h307,
                                                      11'h2EE, 11'h2D5, 11'h36B, 11'h384};
  localparam logic [PCT_W-1:0] HV_UV_WARN_TBL [8] = '{11'h2EE, 11'h2C6, 11'h29E, 11'h276,
                                                      11'h244, 11'h21C, 11'h316, 11'h33E};

  // Switching control states
  typedef enum logic [1:0] {
    BFT_RUN,
    BFT_HIC_WAIT,
    BFT_HIC_DELAY,
    BFT_LATCHED
  } bft_state_t;

endpackage : bft_pkg

// ### logic/bft_thr_decode.sv
`timescale 1ns/1ps
module bft_thr_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stored threshold registers
  input wire logic [7:0] ov_thr,
  input wire logic [7:0] uv_thr,
  // Decoded thresholds, tenths of a percent
  output logic [bft_pkg::PCT_W-1:0] lv_ov_warn_pct,
  output logic [bft_pkg::PCT_W-1:0] lv_ov_prot_pct,
  output logic [bft_pkg::PCT_W-1:0] lv_uv_warn_pct,
  output logic [bft_pkg::PCT_W-1:0] hv_uv_warn_pct
);

  logic [bft_pkg::PCT_W-1:0] pct_next [4];
  logic [bft_pkg::PCT_W-1:0] pct_reg [4];

  // Table lookups, one per field
  always_comb begin
    pct_next[0] = bft_pkg::LV_OV_WARN_TBL[ov_thr[bft_pkg::WARN_LSB +: 3]];
    pct_next[1] = bft_pkg::LV_OV_PROT_TBL[ov_thr[bft_pkg::PROT_LSB +: 3]];
    pct_next[2] = bft_pkg::LV_UV_WARN_TBL[uv_thr[bft_pkg::LV_UV_WARN_LSB +: 3]];
    pct_next[3] = bft_pkg::HV_UV_WARN_TBL[uv_thr[bft_pkg::HV_UV_WARN_LSB +: 3]];
  end

  // Registered so the comparators see glitch-free codes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pct
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pct_reg[gi] <= '0;
        end else begin
          pct_reg[gi] <= pct_next[gi];
        end
      end
    end
  endgenerate

  assign lv_ov_warn_pct = pct_reg[0];
  assign lv_ov_prot_pct = pct_reg[1];
  assign lv_uv_warn_pct = pct_reg[2];
  assign hv_uv_warn_pct = pct_reg[3];

endmodule : bft_thr_decode

// ### verif/bft_host_model.sv
`timescale 1ns/1ps
module bft_host_model (
  // Clock
  input wire logic clk,
  // Command port toward the block
  output logic [7:0] cmd_code,
  output logic cmd_wr_en,
  output logic cmd_rd_en,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata
);
  // Idle bus after power-up
  initial begin
    cmd_code = 8'h00;
    cmd_wr_en = 1'b0;
    cmd_rd_en = 1'b0;
    cmd_wdata = 8'h00;
  end

  // One write strobe; released lines show the inverse so stale data cannot pass
  task automatic write(input logic [7:0] code, input logic [7:0] d);
    cmd_code = code;
    cmd_wdata = d;
    cmd_wr_en = 1'b1;
    @(posedge clk);
    #1;
    cmd_wr_en = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~d;
    @(posedge clk);
    #1;
  endtask : write

  // Write strobe, then a read of the same code on the very next edge
  task automatic write_read(input logic [7:0] code, input logic [7:0] dv, output logic [7:0] q);
    cmd_code = code;
    cmd_wdata = dv;
    cmd_wr_en = 1'b1;
    @(posedge clk);
    #1;
    cmd_wr_en = 1'b0;
    cmd_rd_en = 1'b1;
    @(posedge clk);
    #1;
    cmd_rd_en = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~dv;
    @(posedge clk);
    #1;
    q = cmd_rdata;
  endtask : write_read

  task automatic read(input logic [7:0] code, output logic [7:0] d);
    cmd_code = code;
    cmd_rd_en = 1'b1;
    @(posedge clk);
    #1;
    cmd_rd_en = 1'b0;
    cmd_code = ~code;
    @(posedge clk);
    #1;
    d = cmd_rdata;
  endtask : read
endmodule : bft_host_model

// ### verif/test_bft_config_top.sv
`timescale 1ns/1ps
module test_bft_config_top;
  localparam int HIC = 10;
  localparam int LIMIT = 3000;
  logic clk, rst_n, write_protect, hv_in_uv_detect, status_clr, pwm_enable, chip_enable;
  logic cmd_wr_en, cmd_rd_en, hv_in_uv_status, fault_status_output_out, fault_status_output_oe, pwm_run;
  logic [1:0] mode_pin_resp;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata;
  logic [10:0] lv_ov_warn_pct, lv_ov_prot_pct, lv_uv_warn_pct, hv_uv_warn_pct;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h29;
  // Expected thresholds, tenths of a percent
  logic [10:0] warn_t [8] = '{11'h47E, 11'h44C, 11'h4B0, 11'h4E2, 11'h514, 11'h546, 11'h578, 11'h5AA};
  logic [10:0] prot_t [8] = '{11'h5DC, 11'h578, 11'h514, 11'h640, 11'h6A4, 11'h708, 11'h76C, 11'h7D0};
  logic [10:0] lvuv_t [8] = '{11'h352, 11'h339, 11'h320, 11'h307, 11'h2EE, 11'h2D5, 11'h36B, 11'h384};
  logic [10:0] hvuv_t [8] = '{11'h2EE, 11'h2C6, 11'h29E, 11'h276, 11'h244, 11'h21C, 11'h316, 11'h33E};
  // Mode cases: enable, field, pin, outcome (0 flag, 1 hiccup, 2 latch)
  logic [7:0] mode_t [8] = '{8'h90, 8'hE8, 8'hB1, 8'hC2, 8'h40, 8'h09, 8'h72, 8'h38};
  logic [10:0] exp_q[$];
  int sel_q[$];
  string nm_q[$];
  event look;

  bft_config_top #(.HICCUP_CYCLES(HIC)) i_bft_config_top (.clk(clk), .rst_n(rst_n), .cmd_code(cmd_code),
    .cmd_wr_en(cmd_wr_en), .cmd_rd_en(cmd_rd_en), .cmd_wdata(cmd_wdata), .write_protect(write_protect),
    .cmd_rdata(cmd_rdata), .hv_in_uv_detect(hv_in_uv_detect), .status_clr(status_clr),
    .hv_in_uv_status(hv_in_uv_status), .fault_status_output_out(fault_status_output_out),
    .fault_status_output_oe(fault_status_output_oe), .mode_pin_resp(mode_pin_resp), .pwm_enable(pwm_enable),
    .chip_enable(chip_enable), .pwm_run(pwm_run), .lv_ov_warn_pct(lv_ov_warn_pct),
    .lv_ov_prot_pct(lv_ov_prot_pct), .lv_uv_warn_pct(lv_uv_warn_pct), .hv_uv_warn_pct(hv_uv_warn_pct));
  bft_host_model i_bft_host_model (.clk(clk), .cmd_code(cmd_code), .cmd_wr_en(cmd_wr_en),
    .cmd_rd_en(cmd_rd_en), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  // Observed value by selector
  function automatic logic [10:0] pick(int s);
    case (s)
      0: return {3'h0, cmd_rdata};
      1: return {10'h000, pwm_run};
      2: return {10'h000, hv_in_uv_status};
      3: return {10'h000, fault_status_output_oe};
      4: return lv_ov_warn_pct;
      5: return lv_ov_prot_pct;
      6: return lv_uv_warn_pct;
      8: return {10'h000, fault_status_output_out};
      default: return hv_uv_warn_pct;
    endcase
  endfunction : pick

  // Monitor drains every note, oldest first
  always @(look) begin
    logic [10:0] e, g;
    string n;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      n = nm_q.pop_front();
      g = pick(sel_q.pop_front());
      checked++;
      if (g !== e) begin
        bad_count++;
        $display("unexpected %s: expected %0h seen %0h", n, e, g);
      end
    end
  end

  task automatic chk(string n, int s, logic [10:0] e);
    nm_q.push_back(n);
    sel_q.push_back(s);
    exp_q.push_back(e);
    ->look;
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic rd_chk(string n, logic [7:0] c, logic [7:0] e);
    logic [7:0] d;
    i_bft_host_model.read(c, d);
    chk(n, 0, {3'h0, e});
  endtask : rd_chk

  // One fault under one response setting, then clear
  task automatic fault(logic [7:0] m);
    logic [31:0] r;
    r = xorshift();
    i_bft_host_model.write(bft_pkg::CMD_IND_RESP_EN, {m[7], r[6:0]});
    i_bft_host_model.write(bft_pkg::CMD_FAULT_CTRL, {m[6:5], r[13:8]});
    mode_pin_resp = m[4:3];
    hv_in_uv_detect = 1'b1;
    tick(1);
    status_clr = 1'b1;
    chk("status", 2, 11'h001);
    chk("fault_oe", 3, 11'h001);
    chk("fault_pin", 8, 11'h000);
    chk("pwm_run", 1, {10'h000, m[1:0] == 2'h0});
    tick(1);
    status_clr = 1'b0;
    hv_in_uv_detect = 1'b0;
    chk("status", 2, 11'h001);
    tick(HIC - 1);
    chk("pwm_run", 1, {10'h000, m[1:0] == 2'h0});
    repeat (5) if (pwm_run !== 1'b1) tick(1);
    chk("pwm_run", 1, {10'h000, m[1:0] != 2'h2});
    if (m[1:0] == 2'h2) begin
      if (r[20]) pwm_enable = 1'b0;
      else chip_enable = 1'b0;
      tick(1);
      pwm_enable = 1'b1;
      chip_enable = 1'b1;
      tick(2);
      chk("pwm_run", 1, 11'h001);
    end
    status_clr = 1'b1;
    tick(1);
    status_clr = 1'b0;
    tick(1);
    chk("status", 2, 11'h000);
    chk("fault_oe", 3, 11'h000);
  endtask : fault

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    logic [31:0] r;
    logic [7:0] v;
    logic [2:0] a, b;
    logic [7:0] d;
    rst_n = 1'b0;
    write_protect = 1'b0;
    hv_in_uv_detect = 1'b0;
    status_clr = 1'b0;
    pwm_enable = 1'b1;
    chip_enable = 1'b1;
    mode_pin_resp = 2'h0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    chk("ov_warn", 4, warn_t[0]);
    chk("ov_prot", 5, prot_t[0]);
    chk("uv_lv", 6, lvuv_t[0]);
    chk("uv_hv", 7, hvuv_t[0]);
    rd_chk("ov_thr", bft_pkg::CMD_LOW_BUS_OV_THR, 8'h00);
    rd_chk("uv_thr", bft_pkg::CMD_BUS_UV_WARN_THR, 8'h00);
    // Every code of every field, reserved bits random
    for (int i = 0; i < 8; i++) begin
      r = xorshift();
      a = 3'(i);
      b = a + 3'h3;
      v = {r[7:6], a, b};
      // Back-to-back write and read, new value must already show
      i_bft_host_model.write_read(bft_pkg::CMD_LOW_BUS_OV_THR, v, d);
      chk("ov_thr", 0, {5'h00, v[5:0]});
      chk("ov_warn", 4, warn_t[b]);
      chk("ov_prot", 5, prot_t[a]);
      i_bft_host_model.write(bft_pkg::CMD_BUS_UV_WARN_THR, {r[15:14], b, a});
      rd_chk("uv_thr", bft_pkg::CMD_BUS_UV_WARN_THR, {2'h0, b, a});
      chk("uv_lv", 6, lvuv_t[a]);
      chk("uv_hv", 7, hvuv_t[b]);
    end
    write_protect = 1'b1;
    i_bft_host_model.write(bft_pkg::CMD_LOW_BUS_OV_THR, ~v);
    write_protect = 1'b0;
    rd_chk("ov_protected", bft_pkg::CMD_LOW_BUS_OV_THR, {2'h0, v[5:0]});
    rd_chk("unmapped", 8'hC3, 8'h00);
    for (int i = 0; i < 8; i++) fault(mode_t[i]);
    // Let the monitor drain the last notes before the verdict
    tick(1);
    close_out();
  end
endmodule : test_bft_config_top
